// ===== logic/rsr_regs_map.svh
// register offsets, field positions and reset values of the radio serial receiver
`ifndef RSR_REGS_MAP_SVH
`define RSR_REGS_MAP_SVH

`define RSR_OFF_CTRL1     8'h00
`define RSR_OFF_CTRL2     8'h04
`define RSR_OFF_CTRL3     8'h08
`define RSR_OFF_PATTERN   8'h0C
`define RSR_OFF_RXDATA    8'h10
`define RSR_OFF_STATUS    8'h14
`define RSR_OFF_EVENT     8'h18
`define RSR_OFF_MASK      8'h1C

`define RSR_CTRL1_FINE_LSB   0
`define RSR_CTRL1_COARSE_LSB 4
`define RSR_CTRL2_PCM_LSB    0
`define RSR_CTRL2_EXTCLK_BIT 4
`define RSR_CTRL2_CODEC_BIT  5
`define RSR_CTRL2_START_LSB  6
`define RSR_CTRL3_TXEN_BIT   0
`define RSR_CTRL3_RXEN_BIT   1
`define RSR_CTRL3_MEM_LSB    2
`define RSR_CTRL3_SEL_LSB    5
`define RSR_STAT_OVR_BIT     0
`define RSR_STAT_EMPTY_BIT   1
`define RSR_STAT_FULL_BIT    2
`define RSR_STAT_CNT_LSB     3
`define RSR_STAT_STATE_LSB   8

`define RSR_RST_CTRL1     6'h00
`define RSR_RST_CTRL2     8'h00
`define RSR_RST_PATTERN   8'h00
`define RSR_RST_SEL       3'h0
`define RSR_RST_MASK      4'h0

`define RSR_CHIP_SAMPLES  16
`define RSR_CHIP_MID      4'h7

`endif

// ===== logic/rsr_pkg.sv
// types shared by the radio serial receiver
`default_nettype none
package rsr_pkg;
    typedef enum logic [2:0] {
        RSR_OFF  = 3'b001,
        RSR_HUNT = 3'b010,
        RSR_SYNC = 3'b100
    } rsr_state_t;

    typedef enum logic [1:0] {
        RSR_START_NONE = 2'b00,
        RSR_START_VIOL = 2'b01,
        RSR_START_RSVD = 2'b10,
        RSR_START_PAT  = 2'b11
    } rsr_start_t;
endpackage
`default_nettype wire

// ===== logic/rsr_baud_gen.sv
// prescaler giving one sample tick per (fine+1)*coarse clocks
`default_nettype none
module rsr_baud_gen
    import rsr_pkg::*;
#(
    parameter int CW = 8
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       en,
    input  wire logic [1:0] coarse,
    input  wire logic [3:0] fine,
    output logic            tick
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] div;
    logic [CW-1:0] crs;

    always_comb begin
        unique case (coarse)
            2'b00: crs = CW'(1);
            2'b01: crs = CW'(4);
            2'b10: crs = CW'(8);
            2'b11: crs = CW'(16);
        endcase
        div = CW'((fine + 5'h01) * crs);
    end

    // free running while enabled; chip phase is realigned by the receiver itself
    always_ff @(posedge clk) begin
        if (!rstn || !en) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q >= div - CW'(1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + CW'(1);
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== logic/rsr_rx_fifo.sv
// receive byte fifo in flip-flops with flush
`default_nettype none
module rsr_rx_fifo
    import rsr_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         flush,
    input  wire logic         push,
    input  wire logic [W-1:0] din,
    input  wire logic         pop,
    output logic [W-1:0]      dout,
    output logic [AW:0]       count,
    output logic              full,
    output logic              empty
);
    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic          doPush;
    logic          doPop;

    assign full   = count == (AW+1)'(DEPTH);
    assign empty  = count == '0;
    assign dout   = mem_q[rp_q];
    assign doPop  = pop && !empty;
    assign doPush = push && (!full || doPop);

    always_ff @(posedge clk) begin
        if (!rstn || flush) begin
            wp_q  <= '0;
            rp_q  <= '0;
            count <= '0;
        end else begin
            if (doPush) wp_q <= wp_q + AW'(1);
            if (doPop) rp_q <= rp_q + AW'(1);
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    always_ff @(posedge clk) begin
        if (doPush && !flush) mem_q[wp_q] <= din;
    end
endmodule
`default_nettype wire

// ===== logic/rsr_rx_top.sv
// radio serial receiver: chip recovery, line decoding, start detection, byte fifo, apb registers
// Functional notes
// - receive only when rx on and tx off
// - code 000 decodes nrz level
// - start mode 11 matches 8-bit start pattern
// - irq select 001: start detection only
// - irq select 100: fifo full, held and new events
// - four byte fifo, each data read pops
// - byte into full fifo sets overrun, lost
// - new start detection flushes the fifo
// - ext clock bit 0: internal baud timing
// - coded modes resync on code transitions
// - chip rate clk over (fine+1)*coarse*16
// - irq memory flags sticky, write one clears
// - first received bit lands in bit 0
//
// Implementation choices: the register addresses and the APB slave port.
`include "rsr_regs_map.svh"
`default_nettype none
module rsr_rx_top
    import rsr_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rfData,
    input  wire logic        rfSyncClk,
    output logic             irq
);
    // control registers
    logic [5:0]  ctrl1_q;
    logic [7:0]  ctrl2_q;
    logic [2:0]  irqSel_q;
    logic        rxEn_q;
    logic        txEn_q;
    logic [2:0]  irqMem_q;
    logic [7:0]  pattern_q;
    logic [3:0]  evt_q;
    logic [3:0]  mask_q;
    logic        overrun_q;

    logic [2:0]  lineCode;
    logic        codecEn;
    logic        extClk;
    rsr_start_t  startMode;
    assign lineCode  = ctrl2_q[`RSR_CTRL2_PCM_LSB +: 3];
    assign codecEn   = ctrl2_q[`RSR_CTRL2_CODEC_BIT];
    assign extClk    = ctrl2_q[`RSR_CTRL2_EXTCLK_BIT];
    assign startMode = rsr_start_t'(ctrl2_q[`RSR_CTRL2_START_LSB +: 2]);

    // apb phases
    logic apbAcc;
    logic apbDone;
    logic wrDone;
    logic rdDone;
    assign apbAcc  = psel && penable && !pready;
    assign apbDone = psel && penable && pready;
    assign wrDone  = apbDone && pwrite;
    assign rdDone  = apbDone && !pwrite;

    // receiver state
    rsr_state_t  state_q;
    logic        rxOn;
    logic        dataPrev_q;
    logic        syncPrev_q;
    logic [3:0]  phase_q;
    logic        sampleTick;
    logic        chipStb;
    logic        pairHalf_q;
    logic        firstChip_q;
    logic        lastChip_q;
    logic        prevBit_q;
    logic [7:0]  patSh_q;
    logic [7:0]  byteSh_q;
    logic [2:0]  bitCnt_q;

    assign rxOn = rxEn_q && !txEn_q;

    rsr_baud_gen #(
        .CW     (8)
    ) u_baud (
        .clk    (clk),
        .rstn   (rstn),
        .en     (rxOn),
        .coarse (ctrl1_q[`RSR_CTRL1_COARSE_LSB +: 2]),
        .fine   (ctrl1_q[`RSR_CTRL1_FINE_LSB +: 4]),
        .tick   (sampleTick)
    );

    // chip strobe: mid-chip of the 16 samples, or rising edge of the transceiver's sync clock
    always_comb begin
        if (extClk) chipStb = rxOn && rfSyncClk && !syncPrev_q;
        else chipStb = rxOn && sampleTick && phase_q == `RSR_CHIP_MID;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dataPrev_q <= 1'b0;
            syncPrev_q <= 1'b0;
            phase_q    <= 4'h0;
        end else begin
            dataPrev_q <= rfData;
            syncPrev_q <= rfSyncClk;
            // any line transition restarts the chip phase, so drift never accumulates
            if (!rxOn || rfData != dataPrev_q) phase_q <= 4'h0;
            else if (sampleTick) phase_q <= phase_q + 4'h1;
        end
    end

    // line decoding
    logic pairCode;
    logic bitStb;
    logic bitVal;
    logic viol;
    always_comb begin
        pairCode = codecEn && lineCode[2:0] >= 3'b011;
        bitStb   = 1'b0;
        bitVal   = rfData;
        viol     = 1'b0;
        if (chipStb) begin
            if (!codecEn) begin
                bitStb = 1'b1;
            end else begin
                unique case (lineCode)
                    3'b000: bitStb = 1'b1;
                    3'b001: begin
                        bitStb = 1'b1;
                        bitVal = rfData != lastChip_q;
                    end
                    3'b010: begin
                        bitStb = 1'b1;
                        bitVal = rfData == lastChip_q;
                    end
                    3'b011, 3'b100, 3'b101: begin
                        if (pairHalf_q) begin
                            viol   = firstChip_q == rfData;
                            bitStb = !viol;
                            if (lineCode == 3'b011) bitVal = firstChip_q;
                            else if (lineCode == 3'b100) bitVal = firstChip_q != lastChip_q;
                            else bitVal = firstChip_q == lastChip_q;
                        end
                    end
                    3'b110, 3'b111: begin
                        if (pairHalf_q) begin
                            bitVal = firstChip_q != rfData;
                            viol   = !bitVal && (prevBit_q ? firstChip_q != lastChip_q
                                                           : firstChip_q == lastChip_q);
                            bitStb = !viol;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || !rxOn) begin
            pairHalf_q  <= 1'b0;
            firstChip_q <= 1'b0;
            lastChip_q  <= 1'b0;
            prevBit_q   <= 1'b0;
        end else if (chipStb) begin
            if (pairCode && !pairHalf_q) begin
                firstChip_q <= rfData;
                pairHalf_q  <= 1'b1;
            end else begin
                // a broken pair restarts pairing with the next chip
                pairHalf_q <= 1'b0;
                lastChip_q <= rfData;
                if (bitStb) prevBit_q <= bitVal;
            end
        end
    end

    // start detection
    logic [7:0] patNext;
    logic       startEv;
    assign patNext = {bitVal, patSh_q[7:1]};
    always_comb begin
        unique case (startMode)
            RSR_START_PAT:  startEv = bitStb && patNext == pattern_q;
            RSR_START_VIOL: startEv = viol && pairCode;
            default:        startEv = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn || !rxOn) patSh_q <= 8'h00;
        else if (bitStb) patSh_q <= patNext;
    end

    // byte assembly and fifo
    logic       pushReq;
    logic [7:0] pushByte;
    logic       popReq;
    logic [7:0] fifoOut;
    logic [2:0] fifoCnt;
    logic       fifoFull;
    logic       fifoEmpty;
    logic       byteEv;
    logic       fullEv;
    logic       ovrEv;
    logic       assemble;
    logic       popOk_q;

    assign assemble = bitStb && !startEv && state_q == RSR_SYNC;
    assign pushByte = {bitVal, byteSh_q[7:1]};
    assign pushReq  = assemble && bitCnt_q == 3'h7;
    // pop only a byte that the read really returned; a byte landing mid-access stays queued
    assign popReq   = rdDone && paddr == `RSR_OFF_RXDATA && popOk_q;
    assign ovrEv    = pushReq && fifoFull && !popReq;
    assign byteEv   = pushReq && !ovrEv;
    assign fullEv   = byteEv && !popReq && fifoCnt == 3'(DEPTH - 1);

    always_ff @(posedge clk) begin
        if (!rstn || !rxOn) begin
            state_q  <= RSR_OFF;
            byteSh_q <= 8'h00;
            bitCnt_q <= 3'h0;
        end else begin
            unique case (state_q)
                RSR_OFF: state_q <= (startMode == RSR_START_PAT || startMode == RSR_START_VIOL)
                                    ? RSR_HUNT : RSR_SYNC;
                RSR_HUNT: if (startEv) state_q <= RSR_SYNC;
                RSR_SYNC: ;
            endcase
            if (startEv) begin
                bitCnt_q <= 3'h0;
            end else if (assemble) begin
                byteSh_q <= pushByte;
                bitCnt_q <= bitCnt_q + 3'h1;
            end
        end
    end

    rsr_rx_fifo #(
        .W     (8),
        .DEPTH (DEPTH),
        .AW    (2)
    ) u_fifo (
        .clk   (clk),
        .rstn  (rstn),
        .flush (startEv),
        .push  (pushReq),
        .din   (pushByte),
        .pop   (popReq),
        .dout  (fifoOut),
        .count (fifoCnt),
        .full  (fifoFull),
        .empty (fifoEmpty)
    );

    // register writes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl1_q   <= `RSR_RST_CTRL1;
            ctrl2_q   <= `RSR_RST_CTRL2;
            irqSel_q  <= `RSR_RST_SEL;
            rxEn_q    <= 1'b0;
            txEn_q    <= 1'b0;
            pattern_q <= `RSR_RST_PATTERN;
            mask_q    <= `RSR_RST_MASK;
        end else if (wrDone) begin
            unique case (paddr)
                `RSR_OFF_CTRL1:   ctrl1_q <= pwdata[5:0];
                `RSR_OFF_CTRL2:   ctrl2_q <= pwdata[7:0];
                `RSR_OFF_CTRL3: begin
                    // new source selection gates flags already held as well as later ones
                    irqSel_q <= pwdata[`RSR_CTRL3_SEL_LSB +: 3];
                    rxEn_q   <= pwdata[`RSR_CTRL3_RXEN_BIT];
                    txEn_q   <= pwdata[`RSR_CTRL3_TXEN_BIT];
                end
                `RSR_OFF_PATTERN: pattern_q <= pwdata[7:0];
                `RSR_OFF_MASK:    mask_q <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // sticky flags; a hardware set in the clearing cycle wins
    logic [2:0] memSet;
    logic [2:0] memClr;
    logic [3:0] evtSet;
    assign memSet = {fullEv, byteEv, startEv};
    assign memClr = (wrDone && paddr == `RSR_OFF_CTRL3) ? pwdata[`RSR_CTRL3_MEM_LSB +: 3] : 3'h0;
    assign evtSet = {ovrEv, memSet};

    always_ff @(posedge clk) begin
        if (!rstn) irqMem_q <= 3'h0;
        else irqMem_q <= (irqMem_q & ~memClr) | memSet;
    end

    always_ff @(posedge clk) begin
        if (!rstn) evt_q <= 4'h0;
        // clear only what the read returned, so an event after capture is kept
        else if (rdDone && paddr == `RSR_OFF_EVENT) evt_q <= (evt_q & ~prdata[3:0]) | evtSet;
        else evt_q <= evt_q | evtSet;
    end

    always_ff @(posedge clk) begin
        if (!rstn) overrun_q <= 1'b0;
        else if (ovrEv) overrun_q <= 1'b1;
        else if (wrDone && paddr == `RSR_OFF_STATUS && pwdata[`RSR_STAT_OVR_BIT]) overrun_q <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rstn) irq <= 1'b0;
        else irq <= |(irqMem_q & irqSel_q) || |(evt_q & mask_q);
    end

    // register reads; one wait state, data captured in the first access cycle
    logic [31:0] rdMux;
    logic        hit;
    always_comb begin
        rdMux = 32'h0000_0000;
        hit   = 1'b1;
        unique case (paddr)
            `RSR_OFF_CTRL1:   rdMux[5:0] = ctrl1_q;
            `RSR_OFF_CTRL2:   rdMux[7:0] = ctrl2_q;
            `RSR_OFF_CTRL3:   rdMux[7:0] = {irqSel_q, irqMem_q, rxEn_q, txEn_q};
            `RSR_OFF_PATTERN: rdMux[7:0] = pattern_q;
            `RSR_OFF_RXDATA:  rdMux[7:0] = fifoEmpty ? 8'h00 : fifoOut;
            `RSR_OFF_STATUS: begin
                rdMux[`RSR_STAT_OVR_BIT]        = overrun_q;
                rdMux[`RSR_STAT_EMPTY_BIT]      = fifoEmpty;
                rdMux[`RSR_STAT_FULL_BIT]       = fifoFull;
                rdMux[`RSR_STAT_CNT_LSB +: 3]   = fifoCnt;
                rdMux[`RSR_STAT_STATE_LSB +: 3] = state_q;
            end
            `RSR_OFF_EVENT:   rdMux[3:0] = evt_q;
            `RSR_OFF_MASK:    rdMux[3:0] = mask_q;
            default:          hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            popOk_q <= 1'b0;
        end else begin
            pready  <= apbAcc;
            popOk_q <= apbAcc && !fifoEmpty;
            pslverr <= apbAcc && !hit;
            if (apbAcc && !pwrite) prdata <= rdMux;
        end
    end
endmodule
`default_nettype wire

// ===== bench/rsr_xcvr_model.sv
// behavioural transceiver driving chips and bit-sync clock
`default_nettype none
module rsr_xcvr_model (
    input  wire logic clk,
    output var logic  rfData,
    output var logic  rfSyncClk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rfData = 1'b0;
        rfSyncClk = 1'b0;
    end
    // per 0: sync clock marks each bit, else each chip lasts per clocks
    task automatic send(input logic [7:0] b, input int per);
        for (int i = 0; i < 8; i++) begin
            rfData <= b[i]; // lsb leaves first
            if (per == 0) begin
                repeat (2) @(posedge clk);
                rfSyncClk <= 1'b1;
                repeat (2) @(posedge clk);
                rfSyncClk <= 1'b0;
            end else begin
                repeat (per) @(posedge clk);
            end
        end
    endtask
    // released line flips once, then holds; under internal timing the held level is still sampled as chips
    task automatic idle();
        rfData <= ~rfData;
    endtask
endmodule
`default_nettype wire

// ===== bench/rsr_rx_top_chk.sv
// bus and interrupt assertions on the receiver ports
`include "rsr_regs_map.svh"
`default_nettype none
module rsr_rx_top_chk
    import rsr_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rfData,
    input wire logic        rfSyncClk,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_one_wait: assert property (s_wait |=> s_done)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_err_unmapped: assert property (pready && paddr >= 8'h20 |-> pslverr)
        else $error("unmapped not refused");
    a_ok_mapped: assert property (pready && paddr < 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped refused");
    a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    a_data_byte: assert property (s_done ##0 (!pwrite && paddr == `RSR_OFF_RXDATA) |->
        prdata[31:8] == 24'h00_0000)
        else $error("data upper bits set");
    a_reset_quiet: assert property ($rose(rstn) |-> !irq && !pready && prdata == 32'h0000_0000)
        else $error("outputs busy after reset");
    a_irq_sticky: assert property ($fell(irq) |-> $past(pready, 2))
        else $error("irq fell without software");
endmodule
bind rsr_rx_top rsr_rx_top_chk #(.DEPTH(DEPTH)) rsr_rx_top_chk_inst (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rfData, .rfSyncClk, .irq
);
`default_nettype wire

// ===== bench/test_radio_serial_receiver.sv
// self-checking bench for the radio serial receiver
`include "rsr_regs_map.svh"
`default_nettype none
module test_radio_serial_receiver
    import rsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] r;
        logic        e;
    } rsr_row_t;
    rsr_row_t    rows [6] = '{
        '{`RSR_OFF_CTRL1, 32'h0000_003F, 1'b0},
        '{`RSR_OFF_CTRL2, 32'h0000_00FF, 1'b0},
        '{`RSR_OFF_CTRL3, 32'h0000_00E3, 1'b0},
        '{`RSR_OFF_PATTERN, 32'h0000_00FF, 1'b0},
        '{`RSR_OFF_MASK, 32'h0000_000F, 1'b0},
        '{8'h20, 32'h0000_0000, 1'b1}};
    logic        clk, rstn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, rfData, rfSyncClk, irq, e;
    logic [7:0]  msg [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    int          n_fail, n_checks, chipClks;

    rsr_rx_top #(.DEPTH(4)) rsr_rx_top_inst (
        .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rfData, .rfSyncClk, .irq
    );
    rsr_xcvr_model rsr_xcvr_model_inst (.clk, .rfData, .rfSyncClk);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // request held until pready is sampled, then released
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            chk("pready", 32'h0000_0001, 32'h0000_0000);
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, x, r);
    endtask
    task automatic irq_is(input logic v);
        for (int k = 0; k < 20 && irq !== v; k++) @(posedge clk);
        chk("irq", 32'(v), 32'(irq));
    endtask
    task automatic tx(input logic [7:0] b);
        rsr_xcvr_model_inst.send(b, chipClks);
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_fail = 0;
        n_checks = 0;
        chipClks = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        irq_is(1'b0);
        rd("status rst", `RSR_OFF_STATUS, 32'h0000_0102);
        rd("event rst", `RSR_OFF_EVENT, 32'h0000_0000);
        foreach (rows[i]) begin
            rd("reg rst", rows[i].a, 32'h0000_0000);
            wr(rows[i].a, 32'hFFFF_FFFF);
            chk("wr err", 32'(rows[i].e), 32'(e));
            rd("readback", rows[i].a, rows[i].r);
            chk("rd err", 32'(rows[i].e), 32'(e));
        end
        done("regs");
        // nothing is read before the first start
        wr(`RSR_OFF_CTRL1, 32'h0000_0000);
        wr(`RSR_OFF_CTRL2, 32'h0000_00F0);
        wr(`RSR_OFF_PATTERN, 32'h0000_00D7);
        wr(`RSR_OFF_MASK, 32'h0000_0000);
        wr(`RSR_OFF_CTRL3, 32'h0000_003E);
        rd("hunt", `RSR_OFF_STATUS, 32'h0000_0202);
        tx(8'hD7);
        rsr_xcvr_model_inst.idle();
        irq_is(1'b1);
        rd("mem start", `RSR_OFF_CTRL3, 32'h0000_0026);
        rd("sync", `RSR_OFF_STATUS, 32'h0000_0402);
        wr(`RSR_OFF_CTRL3, 32'h0000_0086);
        irq_is(1'b0);
        for (int i = 0; i < 3; i++) tx(msg[i]);
        irq_is(1'b0);
        tx(msg[3]);
        irq_is(1'b1);
        rd("full", `RSR_OFF_STATUS, 32'h0000_0424);
        // served before the next byte ends
        for (int i = 0; i < 4; i++) rd("data", `RSR_OFF_RXDATA, 32'(msg[i]));
        rd("drained", `RSR_OFF_STATUS, 32'h0000_0402);
        rd("pop empty", `RSR_OFF_RXDATA, 32'h0000_0000);
        wr(`RSR_OFF_CTRL3, 32'h0000_009A);
        irq_is(1'b0);
        done("start");
        for (int i = 0; i < 5; i++) tx(msg[i]);
        rd("overrun", `RSR_OFF_STATUS, 32'h0000_0425);
        for (int i = 0; i < 4; i++) rd("kept", `RSR_OFF_RXDATA, 32'(msg[i]));
        wr(`RSR_OFF_STATUS, 32'h0000_0001);
        rd("ovr clear", `RSR_OFF_STATUS, 32'h0000_0402);
        wr(`RSR_OFF_CTRL3, 32'h0000_001E);
        done("overrun");
        bus(1'b0, `RSR_OFF_EVENT, 32'h0000_0000);
        wr(`RSR_OFF_MASK, 32'h0000_0002);
        irq_is(1'b0);
        tx(msg[0]);
        tx(msg[1]);
        rd("two", `RSR_OFF_STATUS, 32'h0000_0410);
        tx(8'hD7);
        tx(8'h5A);
        rd("flushed", `RSR_OFF_STATUS, 32'h0000_0408);
        rd("after flush", `RSR_OFF_RXDATA, 32'h0000_005A);
        irq_is(1'b1);
        rd("event", `RSR_OFF_EVENT, 32'h0000_0003);
        irq_is(1'b0);
        wr(`RSR_OFF_MASK, 32'h0000_0000);
        done("flush");
        wr(`RSR_OFF_CTRL3, 32'h0000_0003);
        tx(8'hD7);
        tx(8'h33);
        rsr_xcvr_model_inst.idle();
        rd("tx on", `RSR_OFF_STATUS, 32'h0000_0102);
        done("txon");
        // fine 1, coarse 4: 2*4*16 clocks a chip
        wr(`RSR_OFF_CTRL1, 32'h0000_0011);
        wr(`RSR_OFF_CTRL2, 32'h0000_00E0);
        wr(`RSR_OFF_CTRL3, 32'h0000_0002);
        chipClks = 128;
        tx(8'hD7);
        tx(8'h33);
        rd("baud byte", `RSR_OFF_RXDATA, 32'h0000_0033);
        rsr_xcvr_model_inst.idle();
        done("baud");
        // manchester level, start on a violation; pairing counts from the enable
        wr(`RSR_OFF_CTRL3, 32'h0000_0000);
        wr(`RSR_OFF_CTRL1, 32'h0000_0000);
        wr(`RSR_OFF_CTRL2, 32'h0000_0063);
        wr(`RSR_OFF_CTRL3, 32'h0000_003E);
        chipClks = 16;
        tx(8'hFF);
        tx(8'h99);
        tx(8'hA5);
        rd("manchester", `RSR_OFF_RXDATA, 32'h0000_0035);
        done("violation");
        report_and_stop();
    end
endmodule
`default_nettype wire
